/* dv/gpb_tb.sv */
// Self-checking testbench for the general purpose port bank.
`timescale 1ns/1ps
module testbench;
  // Stimulus and observed outputs.
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic mem_wr_en = 1'b0;
  logic mem_rd_en = 1'b0;
  logic [4:0] mem_addr = 5'h00;
  logic [7:0] mem_wr_data = 8'h00;
  logic [7:0] mem_rd_data;
  logic mem_rd_valid;
  logic [55:0] pin_in = 56'h0;
  logic [55:0] pin_out;
  logic [55:0] pin_oe;
  logic [55:0] pin_pullup_en;
  logic [55:0] pin_gpio_sel = 56'hFFFFFFFFFFFFFF;
  logic [55:0] pin_nmos_sel = 56'h0;
  logic sleep_mode = 1'b0;
  logic wake_req;
  int num_errors = 0;
  int checks_done = 0;
  // Expected content of every register, kept by the bench.
  logic [7:0] sh [0:21];

  gpb_port_bank i_gpb_port_bank (.clk(clk), .srst(srst), .ce(ce),
    .mem_wr_en(mem_wr_en), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr),
    .mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data),
    .mem_rd_valid(mem_rd_valid), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_gpio_sel(pin_gpio_sel), .pin_nmos_sel(pin_nmos_sel),
    .sleep_mode(sleep_mode), .wake_req(wake_req));

  // Free-running 40 MHz clock.
  always #12.5 clk = ~clk;

  // Only bits 7, 6, 1 and 0 exist in the port C registers.
  function automatic logic [7:0] msk(input int a);
    msk = (a / 3 == 2 && a < 21) ? 8'hC3 : 8'hFF;
  endfunction : msk

  task automatic check(input logic [55:0] seen, input logic [55:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  // Holds reset for 16 cycles and reloads the expected reset values.
  task automatic reset_all();
    srst <= 1'b1;
    sleep_mode <= 1'b0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a < 22; a++) sh[a] = (a < 21 && a % 3 != 2) ? msk(a) : 8'h00;
  endtask : reset_all

  // One write; the shadow follows only what the block may accept.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    mem_wr_en <= 1'b1;
    mem_addr <= a;
    mem_wr_data <= d;
    @(posedge clk);
    mem_wr_en <= 1'b0;
    if (ce === 1'b1 && a < 5'h16) sh[a] = d & msk(a);
  endtask : wr

  // One read, waited for under a bound and compared with the shadow.
  task automatic rd_chk(input logic [4:0] a);
    logic [7:0] exp;
    int p;
    p = a / 3;
    exp = 8'h00;
    @(posedge clk);
    mem_rd_en <= 1'b1;
    mem_addr <= a;
    @(posedge clk);
    mem_rd_en <= 1'b0;
    if (a < 5'h15 && a % 3 == 0)
      exp = ((pin_in[p*8 +: 8] & sh[a+1]) | (sh[a] & ~sh[a+1])) & msk(a);
    else if (a < 5'h16) exp = sh[a];
    #1;
    for (int i = 0; i < 4 && mem_rd_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check(56'(mem_rd_valid), 56'h1);
    check(56'(mem_rd_data), 56'(exp));
    @(posedge clk);
  endtask : rd_chk

  // Pin outputs two edges after the last write, worked out per port.
  task automatic pins_chk();
    logic [55:0] eo, ee, eu;
    repeat (2) @(posedge clk);
    #1;
    for (int p = 0; p < 7; p++) begin
      eo[p*8 +: 8] = sh[3*p];
      ee[p*8 +: 8] = ~sh[3*p+1] & msk(3*p);
      eu[p*8 +: 8] = sh[3*p+2] & ((pin_gpio_sel[p*8 +: 8] & sh[3*p+1])
                     | pin_nmos_sel[p*8 +: 8]);
    end
    check(pin_out, eo);
    check(pin_oe, ee);
    check(pin_pullup_en, eu);
    @(posedge clk);
  endtask : pins_chk

  // Every register, three unmapped indexes and all pins against reset values.
  task automatic t_regs();
    pin_in <= 56'h3C5AA596C30FF0;
    for (int a = 0; a < 24; a++) rd_chk(a[4:0]);
    rd_chk(5'h1F);
    pins_chk();
  endtask : t_regs

  // All ports as outputs: data reads return the latch, not the pin.
  task automatic t_outputs();
    for (int p = 0; p < 7; p++) begin
      wr(5'(3 * p), 8'hA5 ^ 8'(p * 17));
      wr(5'(3 * p + 1), 8'h00);
    end
    wr(5'h16, 8'h55);
    pin_in <= ~pin_in;
    ce <= 1'b0;
    wr(5'h00, 8'h00);
    ce <= 1'b1;
    pins_chk();
    for (int p = 0; p < 7; p++) rd_chk(5'(3 * p));
  endtask : t_outputs

  // Port B half input, half output, then a single direction bit flipped.
  task automatic t_mixed();
    wr(5'h04, 8'h0F);
    wr(5'h03, 8'h3C);
    pin_in <= 56'h00000000009900;
    rd_chk(5'h03);
    pins_chk();
    wr(5'h04, 8'h1F);
    pins_chk();
    rd_chk(5'h03);
  endtask : t_mixed

  // Pull-high only where the pin is a GPIO input or an open-drain output.
  task automatic t_pullup();
    for (int p = 0; p < 7; p++) begin
      wr(5'(3 * p + 2), 8'hFF);
      wr(5'(3 * p + 1), 8'hF0);
      rd_chk(5'(3 * p + 2));
    end
    pin_gpio_sel <= 56'hCCCCCCCCCCCCCC;
    pin_nmos_sel <= 56'h03030303030303;
    pins_chk();
    pin_gpio_sel <= 56'h0;
    pin_nmos_sel <= 56'h0;
    pins_chk();
    pin_gpio_sel <= 56'hFFFFFFFFFFFFFF;
  endtask : t_pullup

  // One falling edge on port A; wake request expected one cycle later.
  task automatic wake_case(input logic [7:0] fall, input logic slp,
                           input logic exp);
    @(posedge clk);
    pin_in[7:0] <= 8'hFF;
    sleep_mode <= slp;
    @(posedge clk);
    pin_in[7:0] <= ~fall;
    @(posedge clk);
    #1;
    check(56'(wake_req), 56'(exp));
    @(posedge clk);
    #1;
    check(56'(wake_req), 56'h0);
    @(posedge clk);
  endtask : wake_case

  // Enabled bits 0 and 3 only; sleep level must gate the request.
  task automatic t_wake();
    wr(5'h15, 8'h09);
    wr(5'h01, 8'hFF);
    rd_chk(5'h15);
    wake_case(8'h01, 1'b1, 1'b1);
    wake_case(8'h02, 1'b1, 1'b0);
    wake_case(8'h08, 1'b0, 1'b0);
    wake_case(8'h08, 1'b1, 1'b1);
    wr(5'h01, 8'hF7);
    wake_case(8'h08, 1'b1, 1'b0);
    pin_gpio_sel <= 56'hFFFFFFFFFFFFFE;
    wake_case(8'h01, 1'b1, 1'b0);
    pin_gpio_sel <= 56'hFFFFFFFFFFFFFF;
    rd_chk(5'h00);
  endtask : t_wake

  // Main sequence, ending with a mid-run reset that must restore all.
  initial begin
    reset_all();
    t_regs();
    t_outputs();
    t_mixed();
    t_pullup();
    t_wake();
    reset_all();
    t_regs();
    stop_test();
  end

  // Watchdog well beyond the expected run of about 430 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule : testbench

/* hdl/gpb_pkg.sv */
// Constants, register map and decode helpers for the general purpose port bank.
package gpb_pkg;
  localparam int NPORT = 7;
  localparam int PW = 8;
  localparam int NPIN = 56;
  localparam int AW = 5;
  localparam int NREG = 22;
  // Register kinds; each port owns three consecutive indexes.
  localparam logic [1:0] K_DATA = 2'h0;
  localparam logic [1:0] K_DIR = 2'h1;
  localparam logic [1:0] K_PULL = 2'h2;
  localparam logic [1:0] K_WAKE = 2'h3;
  localparam logic [4:0] REGS_PER_PORT = 5'h03;
  localparam logic [4:0] WAKE_IDX = 5'h15;
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  // Implemented-bit masks and reset values.
  localparam logic [7:0] FULL_MASK = 8'hFF;
  localparam logic [7:0] PC_MASK = 8'hC3;
  localparam logic [7:0] DATA_RST = 8'hFF;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] PULL_RST = 8'h00;
  localparam logic [7:0] WAKE_RST = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [55:0] ZERO56 = 56'h0;

  // Index of a port register of the given kind.
  function automatic logic [4:0] gpb_reg_idx(input logic [2:0] port,
                                             input logic [1:0] kind);
    gpb_reg_idx = {2'h0, port} * REGS_PER_PORT + {3'h0, kind};
  endfunction : gpb_reg_idx

  // Port number owning an index.
  function automatic logic [2:0] gpb_port_of(input logic [4:0] addr);
    logic [4:0] q;
    q = addr / REGS_PER_PORT;
    gpb_port_of = q[2:0];
  endfunction : gpb_port_of

  // Kind of register at an index.
  function automatic logic [1:0] gpb_kind_of(input logic [4:0] addr);
    logic [4:0] r;
    r = addr % REGS_PER_PORT;
    gpb_kind_of = (addr == WAKE_IDX) ? K_WAKE : r[1:0];
  endfunction : gpb_kind_of

  // Implemented bits of a port.
  function automatic logic [7:0] gpb_mask_of(input logic [2:0] port);
    gpb_mask_of = (port == PORT_C) ? PC_MASK : FULL_MASK;
  endfunction : gpb_mask_of

  // True for a mapped index.
  function automatic logic gpb_valid(input logic [4:0] addr);
    gpb_valid = (addr <= WAKE_IDX);
  endfunction : gpb_valid

  // Reset value of a mapped index, with unimplemented bits cleared.
  function automatic logic [7:0] gpb_rst_of(input logic [4:0] addr);
    logic [7:0] v;
    case (gpb_kind_of(addr))
      K_DATA: v = DATA_RST;
      K_DIR: v = DIR_RST;
      K_PULL: v = PULL_RST;
      default: v = WAKE_RST;
    endcase
    gpb_rst_of = v & gpb_mask_of(gpb_port_of(addr));
  endfunction : gpb_rst_of
endpackage : gpb_pkg

/* hdl/gpb_port_bank.sv */
// Seven-port general purpose I/O bank with pull-high and port A wake-up.
`timescale 1ns/1ps
module gpb_port_bank (
  // Clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Data-memory access
  input wire logic mem_wr_en,
  input wire logic mem_rd_en,
  input wire logic [4:0] mem_addr,
  input wire logic [7:0] mem_wr_data,
  output logic [7:0] mem_rd_data,
  output logic mem_rd_valid,
  // Pins, port A in bits 7:0 up to port G in bits 55:48
  input wire logic [55:0] pin_in,
  output logic [55:0] pin_out,
  output logic [55:0] pin_oe,
  output logic [55:0] pin_pullup_en,
  // Shared-function selection per pin
  input wire logic [55:0] pin_gpio_sel,
  input wire logic [55:0] pin_nmos_sel,
  // Power management
  input wire logic sleep_mode,
  output logic wake_req
);
  typedef struct packed {
    logic [55:0] pin_out;
    logic [55:0] pin_oe;
    logic [55:0] pin_pull;
    logic [7:0] pa_prev;
    logic wake;
    logic s1_valid;
    logic s1_is_data;
    logic [7:0] s1_pin;
    logic [7:0] s1_dir;
    logic [7:0] s1_mask;
    logic [7:0] rd_data;
    logic rd_valid;
  } gpb_bank_st_t;

  gpb_bank_st_t st_ff;
  gpb_bank_st_t nxt_st;

  logic [gpb_pkg::NREG-1:0][7:0] words;
  logic [7:0] rd_q;
  logic [55:0] data_all;
  logic [55:0] dir_all;
  logic [55:0] pull_all;
  logic [55:0] mask_all;
  logic [7:0] pa_armed;
  logic [2:0] rd_port;

  // Storage for all port registers.
  gpb_regs u_regs (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .wr_en(mem_wr_en),
    .wr_addr(mem_addr),
    .wr_data(mem_wr_data),
    .rd_en(mem_rd_en),
    .rd_addr(mem_addr),
    .rd_q(rd_q),
    .words(words)
  );

  // Flatten the per-port registers into pin-wide vectors.
  always_comb begin
    for (int p = 0; p < gpb_pkg::NPORT; p++) begin
      data_all[p*8 +: 8] =
        words[gpb_pkg::gpb_reg_idx(3'(p), gpb_pkg::K_DATA)];
      dir_all[p*8 +: 8] =
        words[gpb_pkg::gpb_reg_idx(3'(p), gpb_pkg::K_DIR)];
      pull_all[p*8 +: 8] =
        words[gpb_pkg::gpb_reg_idx(3'(p), gpb_pkg::K_PULL)];
      mask_all[p*8 +: 8] = gpb_pkg::gpb_mask_of(3'(p));
    end
  end

  // Port A pins that may wake the device: enabled, input, GPIO function.
  assign pa_armed = words[gpb_pkg::WAKE_IDX] & dir_all[7:0] &
                    pin_gpio_sel[7:0];
  assign rd_port = gpb_pkg::gpb_port_of(mem_addr);

  // Next-state logic: pin drivers, two-stage read path and wake detect.
  always_comb begin
    nxt_st = st_ff;
    // Driver follows the latch on outputs and is off on inputs.
    nxt_st.pin_out = data_all & mask_all;
    nxt_st.pin_oe = ~dir_all & mask_all;
    // Pull-high only for a GPIO input or an open-drain output function.
    nxt_st.pin_pull = pull_all & mask_all &
      ((pin_gpio_sel & dir_all) | pin_nmos_sel);
    // Stage one samples the pin level on the read edge itself.
    nxt_st.s1_valid = mem_rd_en;
    if (mem_rd_en) begin
      nxt_st.s1_is_data = gpb_pkg::gpb_valid(mem_addr) &&
        (gpb_pkg::gpb_kind_of(mem_addr) == gpb_pkg::K_DATA);
      nxt_st.s1_pin = gpb_pkg::ZERO8;
      nxt_st.s1_dir = gpb_pkg::ZERO8;
      nxt_st.s1_mask = gpb_pkg::FULL_MASK;
      if (nxt_st.s1_is_data) begin
        nxt_st.s1_pin = pin_in[int'(rd_port)*8 +: 8];
        nxt_st.s1_dir = dir_all[int'(rd_port)*8 +: 8];
        nxt_st.s1_mask = gpb_pkg::gpb_mask_of(rd_port);
      end
    end
    // Stage two merges pin levels for inputs and latch values for outputs.
    nxt_st.rd_valid = st_ff.s1_valid;
    if (st_ff.s1_valid) begin
      if (st_ff.s1_is_data) begin
        nxt_st.rd_data = ((st_ff.s1_pin & st_ff.s1_dir) |
          (rd_q & ~st_ff.s1_dir)) & st_ff.s1_mask;
      end else begin
        nxt_st.rd_data = rd_q;
      end
    end
    // A high-to-low step on an armed port A pin wakes the core.
    nxt_st.pa_prev = pin_in[7:0];
    nxt_st.wake = sleep_mode &&
      (|(pa_armed & st_ff.pa_prev & ~pin_in[7:0]));
  end

  // State register; reset parks every driver and pull-high off.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register.
  assign pin_out = st_ff.pin_out;
  assign pin_oe = st_ff.pin_oe;
  assign pin_pullup_en = st_ff.pin_pull;
  assign mem_rd_data = st_ff.rd_data;
  assign mem_rd_valid = st_ff.rd_valid;
  assign wake_req = st_ff.wake;

  // Fixed indexes used by the checks below.
  localparam logic [4:0] PB_DATA =
    gpb_pkg::gpb_reg_idx(gpb_pkg::PORT_B, gpb_pkg::K_DATA);
  localparam logic [4:0] PB_DIR =
    gpb_pkg::gpb_reg_idx(gpb_pkg::PORT_B, gpb_pkg::K_DIR);
  localparam logic [4:0] PB_PULL =
    gpb_pkg::gpb_reg_idx(gpb_pkg::PORT_B, gpb_pkg::K_PULL);
  localparam logic [4:0] PC_DATA =
    gpb_pkg::gpb_reg_idx(gpb_pkg::PORT_C, gpb_pkg::K_DATA);

  // A read answers exactly two enabled edges later.
  AST_RD_LATENCY: assert property (
    @(posedge clk) disable iff (srst)
    (ce && mem_rd_en) ##1 ce |=> mem_rd_valid
  ) else $error("read answer missing two cycles after request");

  // An input port read returns the pin level seen at the request edge.
  AST_RD_PIN: assert property (
    @(posedge clk) disable iff (srst)
    (ce && mem_rd_en && !mem_wr_en && mem_addr == PB_DATA &&
     words[PB_DIR] == gpb_pkg::FULL_MASK) ##1 ce
    |=> mem_rd_data == $past(pin_in[15:8], 2)
  ) else $error("input read did not return sampled pin level");

  // An output port read returns the latch, never the pin.
  AST_RD_LATCH: assert property (
    @(posedge clk) disable iff (srst)
    (ce && mem_rd_en && !mem_wr_en && mem_addr == PB_DATA &&
     words[PB_DIR] == gpb_pkg::ZERO8) ##1 ce
    |=> mem_rd_data == $past(words[PB_DATA], 2)
  ) else $error("output read did not return latch value");

  // Without writes the output latches and drivers keep their value.
  AST_LATCH_HOLD: assert property (
    @(posedge clk) disable iff (srst)
    (ce && !mem_wr_en) [*3] |=> $stable(pin_out) && $stable(pin_oe)
  ) else $error("output latch changed without a write");

  // Drivers are enabled exactly on implemented pins set as outputs.
  AST_OE_DIR: assert property (
    @(posedge clk) disable iff (srst)
    ce |=> pin_oe == (~$past(dir_all) & $past(mask_all))
  ) else $error("driver enable does not follow direction");

  // The driven level is the latch value of the pin.
  AST_OUT_LATCH: assert property (
    @(posedge clk) disable iff (srst)
    ce |=> pin_out == ($past(data_all) & $past(mask_all))
  ) else $error("pin driver does not present latch value");

  // No pull-high unless the pin function permits it and the bit is set.
  AST_PULL_GATE: assert property (
    @(posedge clk) disable iff (srst)
    ce |=> (pin_pullup_en & ~(($past(pin_gpio_sel) | $past(pin_nmos_sel)) &
            $past(pull_all))) == gpb_pkg::ZERO56
  ) else $error("pull-high on while not permitted");

  // Unimplemented port C bits always read as zero.
  AST_PC_MASK: assert property (
    @(posedge clk) disable iff (srst)
    (ce && mem_rd_en && mem_addr == PC_DATA) ##1 ce
    |=> (mem_rd_data & ~gpb_pkg::PC_MASK) == gpb_pkg::ZERO8
  ) else $error("unimplemented port C bit read as one");

  // In sleep, a falling edge on armed port A pin 0 raises a wake request.
  AST_WAKE: assert property (
    @(posedge clk) disable iff (srst)
    ce && sleep_mode && pa_armed[0] && st_ff.pa_prev[0] && !pin_in[0]
    |=> wake_req
  ) else $error("port A falling edge did not wake the device");

  // Reset leaves no driver and no pull-high enabled.
  AST_RESET: assert property (
    @(posedge clk)
    srst |=> pin_oe == gpb_pkg::ZERO56 && pin_pullup_en == gpb_pkg::ZERO56
  ) else $error("reset left a driver or pull-high on");

  // Without a read request no answer follows two cycles later.
  AST_RD_QUIET: assert property (
    @(posedge clk) disable iff (srst)
    (ce && !mem_rd_en) ##1 ce |=> !mem_rd_valid
  ) else $error("read answer without a request");

  // Indexes beyond the map read back as zero.
  AST_RD_UNMAPPED: assert property (
    @(posedge clk) disable iff (srst)
    (ce && mem_rd_en && mem_addr > gpb_pkg::WAKE_IDX) ##1 ce
    |=> mem_rd_data == gpb_pkg::ZERO8
  ) else $error("unmapped index did not read as zero");

  // Writes beyond the map leave every register untouched.
  AST_WR_UNMAPPED: assert property (
    @(posedge clk) disable iff (srst)
    ce && mem_wr_en && mem_addr > gpb_pkg::WAKE_IDX |=> $stable(words)
  ) else $error("unmapped write changed a register");

  // A data write lands in the output latch at the next edge.
  AST_WR_DATA: assert property (
    @(posedge clk) disable iff (srst)
    ce && mem_wr_en && mem_addr == PB_DATA
    |=> words[PB_DATA] == $past(mem_wr_data)
  ) else $error("data write did not reach the output latch");

  // The output latch moves only when it is written.
  AST_DATA_KEEP: assert property (
    @(posedge clk) disable iff (srst)
    !(ce && mem_wr_en && mem_addr == PB_DATA) |=> $stable(words[PB_DATA])
  ) else $error("output latch changed without a write");

  // A direction write takes effect at the next edge.
  AST_WR_DIR: assert property (
    @(posedge clk) disable iff (srst)
    ce && mem_wr_en && mem_addr == PB_DIR
    |=> words[PB_DIR] == $past(mem_wr_data)
  ) else $error("direction write did not land");

  // A pull-high write takes effect at the next edge.
  AST_WR_PULL: assert property (
    @(posedge clk) disable iff (srst)
    ce && mem_wr_en && mem_addr == PB_PULL
    |=> words[PB_PULL] == $past(mem_wr_data)
  ) else $error("pull-high write did not land");

  // Only the implemented port C bits are stored.
  AST_WR_PC: assert property (
    @(posedge clk) disable iff (srst)
    ce && mem_wr_en && mem_addr == PC_DATA
    |=> words[PC_DATA] == ($past(mem_wr_data) & gpb_pkg::PC_MASK)
  ) else $error("port C stored an unimplemented bit");

  // The port A wake enable register stores a full byte.
  AST_WR_WAKE: assert property (
    @(posedge clk) disable iff (srst)
    ce && mem_wr_en && mem_addr == gpb_pkg::WAKE_IDX
    |=> words[gpb_pkg::WAKE_IDX] == $past(mem_wr_data)
  ) else $error("wake enable write did not land");

  // An enabled pull-high on a GPIO input is switched on.
  AST_PULL_ON: assert property (
    @(posedge clk) disable iff (srst)
    ce |=> (~pin_pullup_en & $past(pin_gpio_sel) & $past(dir_all) &
            $past(pull_all) & $past(mask_all)) == gpb_pkg::ZERO56
  ) else $error("permitted pull-high stayed off");

  // A push-pull output never gets a pull-high, which would waste current.
  AST_PULL_OUT: assert property (
    @(posedge clk) disable iff (srst)
    ce |=> (pin_pullup_en & ~$past(dir_all) & ~$past(pin_nmos_sel)) ==
           gpb_pkg::ZERO56
  ) else $error("pull-high on a push-pull output");

  // Missing port C pins stay quiet, so no absent pad is ever driven.
  AST_PC_PINS: assert property (
    @(posedge clk) disable iff (srst)
    ((pin_oe | pin_out | pin_pullup_en) & ~mask_all) == gpb_pkg::ZERO56
  ) else $error("unimplemented port C pin is active");

  // No wake request leaves the bank outside sleep mode.
  AST_WAKE_AWAKE: assert property (
    @(posedge clk) disable iff (srst)
    ce && !sleep_mode |=> !wake_req
  ) else $error("wake request while running");

  // Without a falling edge on an armed pin there is no wake request.
  AST_WAKE_CAUSE: assert property (
    @(posedge clk) disable iff (srst)
    ce && (pa_armed & st_ff.pa_prev & ~pin_in[7:0]) == gpb_pkg::ZERO8
    |=> !wake_req
  ) else $error("wake request without an armed falling edge");
endmodule : gpb_port_bank

/* hdl/gpb_regs.sv */
// Register storage of the port bank with a registered read port.
`timescale 1ns/1ps
module gpb_regs (
  // Clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Write port
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [4:0] rd_addr,
  output logic [7:0] rd_q,
  // All stored words, for the pin logic
  output logic [gpb_pkg::NREG-1:0][7:0] words
);
  typedef struct packed {
    logic [gpb_pkg::NREG-1:0][7:0] mem;
    logic [7:0] rd_q;
  } gpb_regs_st_t;

  gpb_regs_st_t st_ff;
  gpb_regs_st_t nxt_st;
  gpb_regs_st_t rst_st;

  // Writes store only implemented bits; the whole byte is replaced, so bits
  // that equal their old value simply keep it.
  always_comb begin
    nxt_st = st_ff;
    rst_st.rd_q = gpb_pkg::ZERO8;
    for (int i = 0; i < gpb_pkg::NREG; i++) begin
      rst_st.mem[i] = gpb_pkg::gpb_rst_of(5'(i));
    end
    if (wr_en && gpb_pkg::gpb_valid(wr_addr)) begin
      nxt_st.mem[wr_addr] = wr_data &
        gpb_pkg::gpb_mask_of(gpb_pkg::gpb_port_of(wr_addr));
    end
    if (rd_en) begin
      nxt_st.rd_q = gpb_pkg::gpb_valid(rd_addr) ? st_ff.mem[rd_addr]
                                                : gpb_pkg::ZERO8;
    end
  end

  // Reset loads documented values; a low enable freezes everything.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= rst_st;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign rd_q = st_ff.rd_q;
  assign words = st_ff.mem;
endmodule : gpb_regs
